// [verilog/twdps_regs.vh]
/*
 Constants for the two-wire debug link registers and frames.
 Assumes inclusion by bare name from design files.
*/
`ifndef TWDPS_REGS_VH
`define TWDPS_REGS_VH
`define TWDPS_ADDR_DEVID 8'h00
`define TWDPS_ADDR_REVID 8'h01
`define TWDPS_ADDR_FLCTL 8'h02
`define TWDPS_ADDR_FLDAT 8'hb4
`define TWDPS_RST_ADDR 8'h00
`define TWDPS_RST_FLCTL 8'h00
`define TWDPS_RST_FLDAT 8'h00
`define TWDPS_INS_DATA_RD 2'h0
`define TWDPS_INS_ADDR_RD 2'h2
`define TWDPS_INS_DATA_WR 2'h1
`define TWDPS_INS_ADDR_WR 2'h3
`define TWDPS_WAIT_CYC 4'h2
`endif

// [verilog/twdps_sync.v]
/*
 Two-flop synchroniser for one level from outside the clock domain.
 Assumes the input is asynchronous to clk_i.
*/
`timescale 1ns/1ps
module twdps_sync
#(
  parameter RST_VAL = 1'b0
)
(
  input wire clk_i,
  input wire rst_i,
  input wire async_i,
  output wire sync_o
);
  reg meta_q;
  reg sync_q;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end
  assign sync_o = sync_q;
endmodule

// [verilog/twdps_top.v]
/*
 Device end of the two-wire debug link, with pin sharing of the reset
 and the shared port pin. Link registers sit behind the link only.
 Assumes the host clocks the link only while the core is halted, and
 that the link clock is much slower than core_clk_i.
*/
// How it works
// - One host link clock and one two-way data line carry all traffic
// - Link address, identity and flash registers are reachable only by link
// - Flash, boundary scan and debug served over the link in the end system
// - Link traffic is served while the core is halted, peripherals stalled
// - While halted, reset pin acts as link clock and port pin as link data
`timescale 1ns/1ps
`include "twdps_regs.vh"
module twdps_top
#(
  parameter DEV_ID = 8'h5a,
  parameter REV_ID = 8'h01
)
(
  input wire core_clk_i,
  input wire rst_i,
  input wire halted_i,
  input wire reset_pin_i,
  input wire shared_port_pin_i,
  input wire user_port_o_i,
  input wire user_port_oe_i,
  output wire shared_port_pin_o,
  output wire shared_port_pin_oe_o,
  output wire user_reset_n_o,
  output wire user_port_i_o,
  output reg [7:0] flash_program_control_o,
  output reg [7:0] flash_data_wr_o,
  output reg flash_data_wr_stb_o,
  input wire [7:0] flash_data_rd_i
);
  // DEV_ID and REV_ID defaults are arbitrary values.
  localparam S_IDLE = 3'h0;
  localparam S_INS = 3'h1;
  localparam S_LEN = 3'h2;
  localparam S_WDATA = 3'h3;
  localparam S_WAIT = 3'h4;
  localparam S_RDATA = 3'h5;
  localparam S_STOP = 3'h6;

  //////////////////////////////////////////////////////////////////////
  wire clk_s;
  wire dat_s;
  // Link clock idles high; a low reset value would fake an edge
  twdps_sync #(.RST_VAL(1'b1)) u_sync_clk
  (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i(reset_pin_i),
    .sync_o(clk_s)
  );
  twdps_sync u_sync_dat
  (
    .clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i(shared_port_pin_i),
    .sync_o(dat_s)
  );
  reg clk_prev_q;
  reg [2:0] st_q;
  reg [1:0] ins_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  reg [7:0] addr_q;
  reg drv_q;
  reg dout_q;
  wire rise = clk_s & ~clk_prev_q;
  wire fall = ~clk_s & clk_prev_q;
  wire active = halted_i;

  // Registers other than addr_q are only visible through this mux on the link
  reg [7:0] rd_val;
  always @*
  begin
    rd_val = 8'h00;
    case (addr_q)
      `TWDPS_ADDR_DEVID: rd_val = DEV_ID;
      `TWDPS_ADDR_REVID: rd_val = REV_ID;
      `TWDPS_ADDR_FLCTL: rd_val = flash_program_control_o;
      `TWDPS_ADDR_FLDAT: rd_val = flash_data_rd_i;
      default: rd_val = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      clk_prev_q <= 1'b1;
      st_q <= S_IDLE;
      ins_q <= 2'h0;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      addr_q <= `TWDPS_RST_ADDR;
      drv_q <= 1'b0;
      dout_q <= 1'b0;
      flash_program_control_o <= `TWDPS_RST_FLCTL;
      flash_data_wr_o <= `TWDPS_RST_FLDAT;
      flash_data_wr_stb_o <= 1'b0;
    end
    else
    begin
      clk_prev_q <= clk_s;
      flash_data_wr_stb_o <= 1'b0;
      if (!active)
      begin
        // Leaving halt aborts any frame and frees the data pin
        st_q <= S_IDLE;
        drv_q <= 1'b0;
      end
      else if (rise)
      begin
        case (st_q)
          S_IDLE:
          begin
            // Start bit is one clock with the line ignored
            st_q <= S_INS;
            cnt_q <= 4'h0;
          end
          S_INS:
          begin
            ins_q <= {dat_s, ins_q[1]};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h1)
            begin
              cnt_q <= 4'h0;
              if ({dat_s, ins_q[1]} == `TWDPS_INS_ADDR_WR)
                st_q <= S_WDATA;
              else if ({dat_s, ins_q[1]} == `TWDPS_INS_ADDR_RD)
              begin
                sh_q <= addr_q;
                st_q <= S_RDATA;
              end
              else
                st_q <= S_LEN;
            end
          end
          S_LEN:
          begin
            // Length field: single-byte transfers only are used
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h1)
            begin
              cnt_q <= 4'h0;
              st_q <= (ins_q == `TWDPS_INS_DATA_WR) ? S_WDATA : S_WAIT;
            end
          end
          S_WDATA:
          begin
            sh_q <= {dat_s, sh_q[7:1]};
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h7)
            begin
              cnt_q <= 4'h0;
              st_q <= S_STOP;
              if (ins_q == `TWDPS_INS_ADDR_WR)
                addr_q <= {dat_s, sh_q[7:1]};
              else if (addr_q == `TWDPS_ADDR_FLCTL)
                flash_program_control_o <= {dat_s, sh_q[7:1]};
              else if (addr_q == `TWDPS_ADDR_FLDAT)
              begin
                flash_data_wr_o <= {dat_s, sh_q[7:1]};
                flash_data_wr_stb_o <= 1'b1;
              end
            end
          end
          S_WAIT:
          begin
            // Fixed wait of three link clocks; no ready bit is sent
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == `TWDPS_WAIT_CYC)
            begin
              cnt_q <= 4'h0;
              sh_q <= rd_val;
              st_q <= S_RDATA;
            end
          end
          S_RDATA:
          begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h8)
            begin
              cnt_q <= 4'h0;
              st_q <= S_STOP;
            end
          end
          S_STOP:
            st_q <= S_IDLE;
          default:
            st_q <= S_IDLE;
        endcase
      end
      else if (fall && active)
      begin
        // Data is launched on the falling link clock edge
        if (st_q == S_RDATA && cnt_q != 4'h8)
        begin
          drv_q <= 1'b1;
          dout_q <= sh_q[0];
          sh_q <= {1'b0, sh_q[7:1]};
        end
        else
          drv_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pin sharing: user logic owns the pins when not halted
  assign shared_port_pin_oe_o = active ? drv_q : user_port_oe_i;
  assign shared_port_pin_o = active ? dout_q : user_port_o_i;
  // Reset pin is input only; while halted its pulses are link clocks
  assign user_reset_n_o = active ? 1'b1 : clk_s;
  assign user_port_i_o = dat_s;
endmodule

// [verif/twdps_properties.sv]
/* Pin sharing and flash write checker for twdps_top.
 Assumes it is bound to twdps_top. */
`timescale 1ns/1ps
module twdps_props
(
  input wire core_clk_i,
  input wire rst_i,
  input wire halted_i,
  input wire reset_pin_i,
  input wire shared_port_pin_i,
  input wire user_port_o_i,
  input wire user_port_oe_i,
  input wire shared_port_pin_o,
  input wire shared_port_pin_oe_o,
  input wire user_reset_n_o,
  input wire user_port_i_o,
  input wire [7:0] flash_program_control_o,
  input wire flash_data_wr_stb_o
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  // Clock parked high past any half period: no frame
  sequence s_idle;
    (halted_i && reset_pin_i) [*8];
  endsequence
  // Long enough for the synced link lines to settle
  sequence s_user;
    (!halted_i) [*5];
  endsequence
  AST_USR_OE: assert property (!halted_i |->
    shared_port_pin_oe_o == user_port_oe_i) else $error("oe");
  AST_USR_DO: assert property (!halted_i |->
    shared_port_pin_o == user_port_o_i) else $error("dout");
  AST_RST_HLD: assert property (halted_i |->
    user_reset_n_o) else $error("rst held");
  AST_RST_HI: assert property ((!halted_i && reset_pin_i) [*4]
    |-> user_reset_n_o) else $error("rst hi");
  AST_RST_LO: assert property ((!halted_i && !reset_pin_i) [*4]
    |-> !user_reset_n_o) else $error("rst lo");
  AST_PIN_IN: assert property ($stable(shared_port_pin_i) [*4]
    |-> user_port_i_o == shared_port_pin_i) else $error("pin in");
  AST_STB_ONE: assert property (flash_data_wr_stb_o |=>
    !flash_data_wr_stb_o) else $error("stb");
  AST_NO_WR: assert property (s_user |-> !flash_data_wr_stb_o &&
    $stable(flash_program_control_o)) else $error("refuse");
  AST_IDLE_REL: assert property (s_idle |->
    !shared_port_pin_oe_o) else $error("release");
endmodule
bind twdps_top twdps_props u_props (.core_clk_i, .rst_i, .halted_i,
  .reset_pin_i, .shared_port_pin_i, .user_port_o_i, .user_port_oe_i,
  .shared_port_pin_o, .shared_port_pin_oe_o, .user_reset_n_o,
  .user_port_i_o, .flash_program_control_o, .flash_data_wr_stb_o);

// [verif/twdps_host.sv]
/* Host debugger model: link clock and data frames.
 Assumes line_i is the resolved data wire with pull-up. */
`timescale 1ns/1ps
module twdps_host
(
  output reg lck_o,
  output reg oe_o,
  output reg d_o,
  input wire line_i
);
  reg b;
  initial
  begin
    lck_o = 1'b1;
    oe_o = 1'b0;
    d_o = 1'b0;
  end
  // Data moves in the low phase only, never near a rising edge
  task pulse(input o, input v);
  begin
    lck_o = 1'b0;
    #4;
    oe_o = o;
    d_o = v;
    #12;
    lck_o = 1'b1;
    #16;
    b = line_i;
  end
  endtask
  task xfer(input [1:0] ins, input [7:0] wd, output [7:0] rd);
    integer i;
  begin
    rd = 8'h00;
    pulse(1'b0, 1'b0);
    for (i = 0; i < 2; i = i + 1)
      pulse(1'b1, ins[i]);
    if (!ins[1])
      repeat (2) pulse(1'b1, 1'b0);
    if (ins == 2'h0)
      repeat (3) pulse(1'b0, 1'b0);
    for (i = 0; i < 8; i = i + 1)
    begin
      pulse(ins[0], wd[i]);
      rd[i] = b;
    end
    pulse(1'b0, 1'b0);
    // Reads close with two idle clocks: release, then frame end
    if (!ins[0])
      pulse(1'b0, 1'b0);
  end
  endtask
endmodule

// [verif/tb_top.sv]
/* Self-checking bench for twdps_top.
 Assumes the checker binds itself and the host model drives the link. */
`timescale 1ns/1ps
module tb_top;
  localparam [7:0] ID = 8'h6e; // Arbitrary identity value
  localparam [7:0] REV = 8'h27; // Arbitrary revision value
  reg clk, rst, halted, uo, uoe;
  reg [7:0] rdi, r;
  integer fail_count, samples_checked, n_stb;
  wire po, poe, urn, upi, stb, lck, hoe, hd;
  wire [7:0] fpc, fwd;
  wire dline = poe ? po : hoe ? hd : 1'b1;
  twdps_top #(.DEV_ID(ID), .REV_ID(REV)) DUT (.core_clk_i(clk),
    .rst_i(rst),
    .halted_i(halted), .reset_pin_i(lck), .shared_port_pin_i(dline),
    .user_port_o_i(uo), .user_port_oe_i(uoe), .shared_port_pin_o(po),
    .shared_port_pin_oe_o(poe), .user_reset_n_o(urn),
    .user_port_i_o(upi), .flash_program_control_o(fpc),
    .flash_data_wr_o(fwd), .flash_data_wr_stb_o(stb),
    .flash_data_rd_i(rdi));
  twdps_host host (.lck_o(lck), .oe_o(hoe), .d_o(hd), .line_i(dline));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
    if (stb === 1'b1)
      n_stb = n_stb + 1;
  task chk(input [7:0] g, input [7:0] e);
  begin
    samples_checked = samples_checked + 1;
    if (g !== e)
    begin
      fail_count = fail_count + 1;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  end
  endtask
  task wait_n(input integer n);
  begin
    repeat (n) @(posedge clk);
    #1;
  end
  endtask
  task stop_test;
  begin
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  task t_user;
  begin
    uoe = 1'b1;
    host.lck_o = 1'b0;
    wait_n(6);
    chk(poe, 1'b1);
    chk(upi, 1'b0);
    chk(urn, 1'b0);
    uoe = 1'b0;
    host.lck_o = 1'b1;
    wait_n(6);
    chk(upi, 1'b1);
    chk(urn, 1'b1);
    host.xfer(2'h3, 8'h02, r);
    host.xfer(2'h1, 8'h77, r);
    wait_n(6);
    chk(fpc, 8'h00);
    $display("t_user done");
  end
  endtask
  task t_link;
  begin
    halted = 1'b1;
    wait_n(4);
    chk(urn, 1'b1);
    host.xfer(2'h3, 8'h02, r);
    host.xfer(2'h1, 8'ha5, r);
    host.xfer(2'h2, 8'h00, r);
    chk(r, 8'h02);
    wait_n(2);
    chk(fpc, 8'ha5);
    host.xfer(2'h0, 8'h00, r);
    chk(r, 8'ha5);
    host.xfer(2'h3, 8'h01, r);
    host.xfer(2'h0, 8'h00, r);
    chk(r, REV);
    host.xfer(2'h3, 8'hb4, r);
    host.xfer(2'h1, 8'h3c, r);
    wait_n(2);
    chk(fwd, 8'h3c);
    chk(n_stb[7:0], 8'h01);
    host.xfer(2'h3, 8'h00, r);
    host.xfer(2'h0, 8'h00, r);
    chk(r, ID);
    host.xfer(2'h3, 8'hb4, r);
    host.xfer(2'h0, 8'h00, r);
    chk(r, 8'hc3);
    $display("t_link done");
  end
  endtask
  task t_leave;
  begin
    halted = 1'b0;
    uo = 1'b1;
    wait_n(2);
    chk(poe, 1'b0);
    chk(po, 1'b1);
    chk(urn, 1'b1);
    $display("t_leave done");
  end
  endtask
  initial
  begin
    fail_count = 0;
    samples_checked = 0;
    n_stb = 0;
    rst = 1'b1;
    halted = 1'b0;
    uo = 1'b0;
    uoe = 1'b0;
    rdi = 8'hc3;
    wait_n(10);
    rst = 1'b0;
    wait_n(4);
    t_user;
    t_link;
    t_leave;
    stop_test;
  end
  // Tests need about 6.5 us; a stuck frame is cut off well after
  initial
  begin
    #50000;
    fail_count = fail_count + 1;
    stop_test;
  end
endmodule
